// file: hdl/dpf_pkg.sv
// constants, types and state layout for the framing, coding and interleaving transmitter
package dpf_pkg;

    // octet fifo in front of the serialiser
    localparam int       FIFO_W      = 8;
    localparam int       FIFO_D      = 4;

    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_LEN   = 4'h4;
    localparam logic [3:0] OFS_STAT  = 4'h8;
    localparam logic [3:0] OFS_DATA  = 4'hC;

    // control register field positions
    localparam int       CTRL_START  = 0;
    localparam int       CTRL_FIXED  = 1;
    localparam int       CTRL_PRE    = 2;
    localparam int       CTRL_FRAG   = 4;

    // preamble and fragment size selections
    localparam logic [1:0] PRE_NONE  = 2'h0;
    localparam logic [1:0] PRE_2     = 2'h1;
    localparam logic [1:0] PRE_4     = 2'h2;
    localparam logic [1:0] FRAG_256  = 2'h0;
    localparam logic [1:0] FRAG_384  = 2'h1;
    localparam logic [1:0] FRAG_512  = 2'h2;
    localparam logic [9:0] FLEN_256  = 10'h100;
    localparam logic [9:0] FLEN_384  = 10'h180;
    localparam logic [9:0] FLEN_512  = 10'h200;

    // header patterns, field lengths in bits, short header limit and reset length in octets
    localparam logic [14:0] PRE16    = 15'h60A6;
    localparam logic [5:0] PRE16_LEN = 6'h0F;
    localparam logic [5:0] PRE32_LEN = 6'h20;
    localparam logic [5:0] SFD_LEN   = 6'h08;
    localparam logic [5:0] PHR1_LEN  = 6'h08;
    localparam logic [5:0] PHR2_LEN  = 6'h10;
    localparam logic [11:0] SHORT_MAX = 12'h080;
    localparam logic [11:0] LEN_RST  = 12'h001;

    // encoder constants
    localparam logic [6:0] GEN0      = 7'h5B;
    localparam logic [6:0] GEN1      = 7'h79;
    localparam logic [2:0] TAIL_LEN  = 3'h6;
    localparam logic [3:0] OCT_LEN   = 4'h8;

    typedef enum logic [2:0] {DPF_IDLE, DPF_PRE, DPF_SFD, DPF_PHR, DPF_FILL, DPF_DRAIN} dpf_state_e;

    // frame configuration held by software
    typedef struct packed {
        logic        fixed;
        logic [1:0]  pre;
        logic [1:0]  frag;
        logic [11:0] len;
    } dpf_cfg_s;

    // outgoing symbol stream
    typedef struct packed {
        logic        valid;
        logic        data;
        logic        coded;
    } dpf_sym_s;

    // state of the transmitter outside the interleaver memory and octet fifo
    typedef struct packed {
        dpf_state_e  state;
        dpf_cfg_s    cfg;
        dpf_cfg_s    run;
        dpf_sym_s    sym;
        logic        busy;
        logic        done;
        logic        done_flag;
        logic        wait_req;
        logic [31:0] rdata;
        logic [31:0] hdr;
        logic [5:0]  hcnt;
        logic [7:0]  oct;
        logic [3:0]  ocnt;
        logic [11:0] left;
        logic [2:0]  tail;
        logic [5:0]  sr;
        logic [9:0]  wr;
        logic [9:0]  rd;
    } dpf_state_s;

endpackage

// file: hdl/dpf_tx.sv
// octet fifo and the framing, encoding and interleaving transmitter top
// Notes on behaviour
// - fields go first to last, octets low first, bits lsb first except the preamble, which goes msb first
// - fixed payload mode sends no preamble, delimiter or length header
// - up to 128 octets: one-octet header holding length minus one
// - 129 to 2048 octets: two-octet header instead
// - short header 0 then 7-bit length; long 1, 4 reserved, 11-bit length
// - preamble 0, 15 or 32 bits; one delimiter octet with a preamble
// - short preamble sends the fixed 15-bit pattern as listed
// - payload plus tail and pad go through the rate one half encoder
// - encoder constraint length 7, generators 133 and 171 octal
// - coded bits reordered by bit reversal over 256, 384 or 512
// - 256 fragment: output position m carries symbol reverse8(m)
// - 384 fragment: 9-bit counter reversed, indices of 384 up skipped
`timescale 1ns/1ps

module dpf_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } dpf_fifo_ptr_s;

    dpf_fifo_ptr_s ptr;
    dpf_fifo_ptr_s next_ptr;
    logic [W-1:0]  mem [D];
    logic          push;
    logic          pop;

    // honest flags from the fill count
    assign in_ready  = (ptr.cnt != (AW+1)'(D));
    assign out_valid = (ptr.cnt != '0);
    assign out_data  = mem[ptr.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        next_ptr = ptr;
        if (push) begin
            next_ptr.wp = (ptr.wp == AW'(D-1)) ? '0 : ptr.wp + AW'(1);
        end
        if (pop) begin
            next_ptr.rp = (ptr.rp == AW'(D-1)) ? '0 : ptr.rp + AW'(1);
        end
        next_ptr.cnt = ptr.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    // storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[ptr.wp] <= in_data;
        end
    end
endmodule // dpf_fifo

module dpf_tx
    import dpf_pkg::*;
#(
    parameter logic [31:0] PRE32 = 32'h0000_0000,
    parameter logic [7:0]  SFD   = 8'h00
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // avalon-mm register slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // symbol stream and frame status
    output dpf_sym_s         sym,
    output logic             busy,
    output logic             frame_done
);
    dpf_state_s  st;
    dpf_state_s  next_st;
    logic        mem [512];
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic        bus_go;
    logic        start;
    logic        enc_en;
    logic        enc_in;
    logic [6:0]  enc_win;
    logic        enc_a;
    logic        enc_b;
    logic [9:0]  flen;
    logic [9:0]  rd_max;
    logic [8:0]  rev;
    logic        mem_bit;
    logic [10:0] phr_n;

    // outputs straight from the state flops
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.wait_req;
    assign sym             = st.sym;
    assign busy            = st.busy;
    assign frame_done      = st.done;

    // bus handshake and push into the octet fifo
    assign bus_go        = (avs_read || avs_write) && !st.wait_req;
    assign fifo_in_valid = bus_go && avs_write && (avs_address == OFS_DATA);
    assign start         = bus_go && avs_write && (avs_address == OFS_CTRL)
                           && avs_writedata[CTRL_START] && !st.busy;

    dpf_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (avs_writedata[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // fragment size and interleaver counter span
    always_comb begin
        case (st.run.frag)
            FRAG_384: flen = FLEN_384;
            FRAG_512: flen = FLEN_512;
            default:  flen = FLEN_256;
        endcase
        rd_max = (st.run.frag == FRAG_256) ? FLEN_256 : FLEN_512;
    end

    // bit reversal of the read counter, 8 or 9 bits wide
    always_comb begin
        rev = '0;
        for (int i = 0; i < 9; i++) begin
            rev[i] = st.rd[8-i];
        end
        if (st.run.frag == FRAG_256) begin
            rev = '0;
            for (int i = 0; i < 8; i++) begin
                rev[i] = st.rd[7-i];
            end
        end
        mem_bit = mem[rev];
    end

    // fill step: pop an octet, encode a payload bit, or encode tail and pad zeros
    assign fifo_out_ready = (st.state == DPF_FILL) && (st.wr < flen) && (st.ocnt == '0) && (st.left != '0);
    assign enc_en = (st.state == DPF_FILL) && (st.wr < flen) && ((st.ocnt != '0) || (st.left == '0));
    assign enc_in  = (st.ocnt != '0) ? st.oct[0] : 1'b0;
    assign enc_win = {enc_in, st.sr};
    assign enc_a   = ^(enc_win & GEN0);
    assign enc_b   = ^(enc_win & GEN1);
    assign phr_n   = 11'(st.run.len - LEN_RST);

    // coded bits stored in pairs, first generator at the lower index
    always_ff @(posedge clock) begin
        if (enc_en) begin
            mem[st.wr[8:0]]             <= enc_a;
            mem[st.wr[8:0] + 9'h001]    <= enc_b;
        end
    end

    // next state of bus, header serialiser, encoder and interleaver
    always_comb begin
        next_st           = st;
        next_st.sym.valid = 1'b0;
        next_st.done      = 1'b0;

        // register slave
        if (!st.wait_req) begin
            next_st.wait_req = 1'b1;
        end else if ((avs_read || avs_write) && (!(avs_write && avs_address == OFS_DATA) || fifo_in_ready)) begin
            next_st.wait_req = 1'b0;
            case (avs_address)
                OFS_CTRL: next_st.rdata = 32'({st.cfg.frag, st.cfg.pre, st.cfg.fixed, 1'b0});
                OFS_LEN:  next_st.rdata = 32'(st.cfg.len);
                OFS_STAT: next_st.rdata = 32'({fifo_in_ready, st.done_flag, st.busy});
                default:  next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (bus_go && avs_write && !st.busy) begin
            if (avs_address == OFS_CTRL) begin
                next_st.cfg.fixed = avs_writedata[CTRL_FIXED];
                next_st.cfg.pre   = avs_writedata[CTRL_PRE +: 2];
                next_st.cfg.frag  = avs_writedata[CTRL_FRAG +: 2];
            end
            if (avs_address == OFS_LEN) begin
                next_st.cfg.len = avs_writedata[11:0];
            end
        end
        if (bus_go && avs_write && (avs_address == OFS_STAT) && avs_writedata[1]) begin
            next_st.done_flag = 1'b0;
        end

        // frame sequencer
        case (st.state)
            DPF_IDLE: begin
                if (start) begin
                    next_st.busy  = 1'b1;
                    next_st.run   = next_st.cfg;
                    next_st.left  = next_st.cfg.len;
                    next_st.ocnt  = '0;
                    next_st.tail  = '0;
                    next_st.sr    = '0;
                    next_st.wr    = '0;
                    if (next_st.cfg.fixed) begin
                        next_st.state = DPF_FILL;
                    end else if (next_st.cfg.pre == PRE_4) begin
                        next_st.state = DPF_PRE;
                        next_st.hdr   = PRE32;
                        next_st.hcnt  = PRE32_LEN;
                    end else if (next_st.cfg.pre == PRE_2) begin
                        next_st.state = DPF_PRE;
                        next_st.hdr   = {PRE16, 17'h0_0000};
                        next_st.hcnt  = PRE16_LEN;
                    end else begin
                        // all ones marks a length header still to be loaded
                        next_st.state = DPF_PHR;
                        next_st.hdr   = 32'hFFFF_FFFF;
                        next_st.hcnt  = '0;
                    end
                end
            end
            DPF_PRE, DPF_SFD, DPF_PHR: begin
                if (st.hcnt != '0) begin
                    next_st.sym.valid = 1'b1;
                    next_st.sym.coded = 1'b0;
                    next_st.hcnt      = st.hcnt - 6'h01;
                    if (st.state == DPF_PRE) begin
                        next_st.sym.data = st.hdr[31];
                        next_st.hdr      = {st.hdr[30:0], 1'b0};
                    end else begin
                        next_st.sym.data = st.hdr[0];
                        next_st.hdr      = {1'b0, st.hdr[31:1]};
                    end
                end else if (st.state == DPF_PRE) begin
                    next_st.state = DPF_SFD;
                    next_st.hdr   = 32'(SFD);
                    next_st.hcnt  = SFD_LEN;
                end else if (st.state == DPF_SFD || st.hdr == 32'hFFFF_FFFF) begin
                    next_st.state = DPF_PHR;
                    next_st.hdr   = '0;
                    if (st.run.len > SHORT_MAX) begin
                        next_st.hdr  = 32'({phr_n, 4'h0, 1'b1});
                        next_st.hcnt = PHR2_LEN;
                    end else begin
                        next_st.hdr  = 32'({phr_n[6:0], 1'b0});
                        next_st.hcnt = PHR1_LEN;
                    end
                    next_st.hdr[31] = 1'b0;
                end else begin
                    next_st.state = DPF_FILL;
                end
            end
            DPF_FILL: begin
                if (st.wr >= flen) begin
                    next_st.state = DPF_DRAIN;
                    next_st.rd    = '0;
                end else if (fifo_out_ready) begin
                    if (fifo_out_valid) begin
                        next_st.oct  = fifo_out_data;
                        next_st.ocnt = OCT_LEN;
                        next_st.left = st.left - 12'h001;
                    end
                end else begin
                    next_st.sr = {enc_in, st.sr[5:1]};
                    next_st.wr = st.wr + 10'h002;
                    if (st.ocnt != '0) begin
                        next_st.oct  = {1'b0, st.oct[7:1]};
                        next_st.ocnt = st.ocnt - 4'h1;
                    end else if (st.tail != TAIL_LEN) begin
                        next_st.tail = st.tail + 3'h1;
                    end
                end
            end
            DPF_DRAIN: begin
                if (10'(rev) < flen) begin
                    next_st.sym.valid = 1'b1;
                    next_st.sym.coded = 1'b1;
                    next_st.sym.data  = mem_bit;
                end
                next_st.rd = st.rd + 10'h001;
                if (st.rd == rd_max - 10'h001) begin
                    next_st.wr = '0;
                    if (st.left == '0 && st.ocnt == '0 && st.tail == TAIL_LEN) begin
                        next_st.state     = DPF_IDLE;
                        next_st.busy      = 1'b0;
                        next_st.done      = 1'b1;
                        next_st.done_flag = 1'b1;
                    end else begin
                        next_st.state = DPF_FILL;
                    end
                end
            end
            default: begin
                next_st.state = DPF_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            st          <= '0;
            st.state    <= DPF_IDLE;
            st.cfg.len  <= LEN_RST;
            st.run.len  <= LEN_RST;
            st.wait_req <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule // dpf_tx

// file: test/dpf_mac_model.sv
// mac side model: avalon master feeding configuration and payload octets
`timescale 1ns/1ps
module dpf_mac_model (
    // clock
    input  wire logic        clock,
    // avalon-mm master
    output logic [3:0]       avs_address = 4'h0,
    output logic             avs_read = 1'b0,
    output logic             avs_write = 1'b0,
    output logic [31:0]      avs_writedata = 32'h0,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // one transfer, held until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        ok = 1'b0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (int i = 0; i < 4000 && !ok; i++) begin
            @(posedge clock);
            ok = (avs_waitrequest === 1'b0);
            q = avs_readdata;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule // dpf_mac_model

// file: test/dpf_tx_asserts.sv
// port-level assertion checker for the transmitter
`timescale 1ns/1ps
module dpf_tx_asserts
    import dpf_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // register slave
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // symbol stream and status
    input wire dpf_sym_s    sym,
    input wire logic        busy,
    input wire logic        frame_done
);
    logic start_ok;
    logic run_fixed;
    logic seen_coded;

    // accepted start while idle
    assign start_ok = avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_writedata[CTRL_START] && !busy;

    // frame mode and coded-phase trackers
    always_ff @(posedge clock) begin
        if (rst) begin
            run_fixed <= 1'b0;
            seen_coded <= 1'b0;
        end else begin
            if (start_ok) run_fixed <= avs_writedata[CTRL_FIXED];
            if (frame_done) seen_coded <= 1'b0;
            else if (sym.valid && sym.coded) seen_coded <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_ack_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

    property p_no_spur;
        !avs_read && !avs_write |=> avs_waitrequest;
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("ack without request");

    property p_read_ack;
        $rose(avs_read) |-> ##[1:2] !avs_waitrequest;
    endproperty
    a_read_ack: assert property (p_read_ack) else $error("read not answered");

    property p_done_pulse;
        frame_done |-> $fell(busy) ##1 !frame_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse wrong");

    property p_fall_done;
        $fell(busy) |-> frame_done;
    endproperty
    a_fall_done: assert property (p_fall_done) else $error("busy fell without done");

    property p_start_hdr;
        start_ok && !avs_writedata[CTRL_FIXED] |-> ##[1:4] (sym.valid && !sym.coded);
    endproperty
    a_start_hdr: assert property (p_start_hdr) else $error("no header after start");

    property p_fixed_nohdr;
        busy && run_fixed |-> !(sym.valid && !sym.coded);
    endproperty
    a_fixed_nohdr: assert property (p_fixed_nohdr) else $error("header in fixed mode");

    property p_order;
        seen_coded |-> !(sym.valid && !sym.coded);
    endproperty
    a_order: assert property (p_order) else $error("header bit after coded bit");
endmodule // dpf_tx_asserts

bind dpf_tx dpf_tx_asserts dpf_tx_asserts_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sym(sym), .busy(busy), .frame_done(frame_done));

// file: test/dpf_tx_test.sv
// self-checking bench for the framing, coding and interleaving transmitter
`timescale 1ns/1ps
module dpf_tx_test;
    import dpf_pkg::*;
    localparam logic [31:0] P32 = 32'hC3A5_0F96;  // arbitrary long preamble
    localparam logic [7:0]  SFDV = 8'hB4;         // arbitrary delimiter
    localparam logic [14:0] PSH = 15'h60A6;       // short preamble, first bit at msb
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    dpf_sym_s    sym;
    logic        busy;
    logic        frame_done;
    logic [31:0] rv;
    logic        hq[$];
    logic        cq[$];
    logic        eh[$];
    logic        ec[$];
    logic [7:0]  oq[$];
    int          failures = 0;
    int          tests_run = 0;

    always #2 clock = ~clock;

    dpf_tx #(.PRE32(P32), .SFD(SFDV)) dpf_tx_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sym(sym), .busy(busy), .frame_done(frame_done));
    dpf_mac_model dpf_mac_model_inst (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // collect header and coded symbols as they leave
    always @(posedge clock) begin
        if (sym.valid === 1'b1 && sym.coded) cq.push_back(sym.data);
        else if (sym.valid === 1'b1) hq.push_back(sym.data);
    end

    task automatic tally_and_finish;
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic hang;
        failures++;
        tally_and_finish();
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        dpf_mac_model_inst.xfer(1'b1, a, d, q, ok);
        if (!ok) hang();
    endtask

    task automatic rd(input logic [3:0] a);
        logic ok;
        dpf_mac_model_inst.xfer(1'b0, a, 32'h0, rv, ok);
        if (!ok) hang();
    endtask

    task automatic cmpq(input logic q[$], input logic e[$]);
        chk(32'(q.size()), 32'(e.size()));
        for (int i = 0; i < e.size() && i < q.size(); i++) chk({31'h0, q[i]}, {31'h0, e[i]});
    endtask

    // expected header bits and interleaved coded bits
    task automatic expect_frame(input logic [1:0] pre, input logic fx, input int fl);
        logic        b[$];
        logic        c[$];
        logic [5:0]  h;
        logic [6:0]  w;
        logic [15:0] phr;
        int          nb;
        int          r;
        int          p;
        eh = {};
        ec = {};
        if (!fx) begin
            if (pre == PRE_2) for (int i = 14; i >= 0; i--) eh.push_back(PSH[i]);
            if (pre == PRE_4) for (int i = 31; i >= 0; i--) eh.push_back(P32[i]);
            if (pre != PRE_NONE) for (int i = 0; i < 8; i++) eh.push_back(SFDV[i]);
            nb = (oq.size() > 128) ? 16 : 8;
            phr = (nb == 8) ? {8'h00, 7'(oq.size() - 1), 1'b0} : {11'(oq.size() - 1), 4'h0, 1'b1};
            for (int i = 0; i < nb; i++) eh.push_back(phr[i]);
        end
        foreach (oq[k]) for (int i = 0; i < 8; i++) b.push_back(oq[k][i]);
        nb = b.size() + 6;
        while (b.size() < (nb + fl / 2 - 1) / (fl / 2) * (fl / 2)) b.push_back(1'b0);
        h = 6'h00;
        foreach (b[k]) begin
            w = {b[k], h};
            c.push_back(^(w & 7'h5B));
            c.push_back(^(w & 7'h79));
            h = {b[k], h[5:1]};
        end
        p = (fl == 256) ? 8 : 9;
        for (int f = 0; f < c.size() / fl; f++) begin
            for (int m = 0; m < (1 << p); m++) begin
                r = 0;
                for (int k = 0; k < p; k++) r = r * 2 + ((m >> k) & 1);
                if (r < fl) ec.push_back(c[f * fl + r]);
            end
        end
    endtask

    // one frame: load, start, feed the rest under back-pressure, compare
    task automatic run(input logic [1:0] pre, input logic fx, input logic [1:0] frag, input int n);
        int fl;
        int i;
        fl = (frag == FRAG_256) ? 256 : (frag == FRAG_384) ? 384 : 512;
        oq = {};
        hq = {};
        cq = {};
        for (i = 0; i < n; i++) oq.push_back(8'(i * 29 + n));
        wr(OFS_LEN, 32'(n));
        for (i = 0; i < n && i < 4; i++) wr(OFS_DATA, {24'h0, oq[i]});
        rd(OFS_STAT);
        chk(rv, (n < 4) ? 32'h4 : 32'h0);
        wr(OFS_CTRL, {26'h0, frag, pre, fx, 1'b1});
        wr(OFS_LEN, 32'h5);
        chk({30'h0, busy, frame_done}, 32'h2);
        for (i = 4; i < n; i++) wr(OFS_DATA, {24'h0, oq[i]});
        for (i = 0; i < 20000 && frame_done !== 1'b1; i++) @(posedge clock);
        if (i == 20000) hang();
        #1;
        chk({30'h0, busy, frame_done}, 32'h0);
        expect_frame(pre, fx, fl);
        cmpq(hq, eh);
        cmpq(cq, ec);
        rd(OFS_CTRL);
        chk(rv, {26'h0, frag, pre, fx, 1'b0});
        rd(OFS_LEN);
        chk(rv, 32'(n));
        rd(OFS_STAT);
        chk(rv, 32'h6);
        wr(OFS_STAT, 32'h2);
        rd(OFS_STAT);
        chk(rv, 32'h4);
    endtask

    // reset, register defaults, then frames in every mode
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_CTRL);
        chk(rv, 32'h0);
        rd(OFS_LEN);
        chk(rv, 32'h1);
        rd(4'h1);
        chk(rv, 32'h0);
        run(PRE_2, 1'b0, FRAG_256, 2);
        run(PRE_NONE, 1'b1, FRAG_384, 3);
        run(PRE_NONE, 1'b0, FRAG_384, 128);
        run(PRE_4, 1'b0, FRAG_512, 129);
        tally_and_finish();
    end
endmodule // dpf_tx_test
